// ==== logic/bpf_bus_cycle.sv ====
`timescale 1ns/1ps
`default_nettype none
// one asynchronous bus cycle: read or write, timed by counts
module bpf_bus_cycle
   import bpf_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              rstn,
   input  wire logic              start,
   input  wire logic              isWrite,
   input  wire logic              pageHit,
   input  wire logic [ADDR_W-1:0] addr,
   input  wire logic [DATA_W-1:0] wdata,
   input  wire logic [DATA_W-1:0] pinDataIn,
   output logic                   busy,
   output logic                   done,
   output logic [DATA_W-1:0]      rdata,
   output logic [ADDR_W-1:0]      pinAddr,
   output logic [DATA_W-1:0]      pinDataOut,
   output logic                   pinDataOe,
   output logic                   chipEnN,
   output logic                   outEnN,
   output logic                   writeEnN
);
   typedef enum logic [1:0] {BPF_IDLE, BPF_SETUP, BPF_STROBE, BPF_HOLD} bpf_cyc_t;
   bpf_cyc_t          st, next_st;
   logic [CNT_W-1:0]  cnt, next_cnt;
   logic [DATA_W-1:0] next_rdata, next_dOut, syncA, syncB;
   logic [ADDR_W-1:0] next_addr;
   logic              wr, next_wr, next_done, next_oe, next_ce, next_oen, next_wen;

   always_comb begin
      next_st = st;
      next_cnt = cnt;
      next_wr = wr;
      next_rdata = rdata;
      next_addr = pinAddr;
      next_dOut = pinDataOut;
      next_done = 1'b0;
      next_oe = pinDataOe;
      next_ce = chipEnN;
      next_oen = outEnN;
      next_wen = writeEnN;
      unique case (st)
         BPF_IDLE: if (start) begin
            next_wr = isWrite;
            next_addr = addr;
            next_dOut = wdata;
            next_ce = 1'b0;
            next_oe = isWrite;
            next_cnt = CNT_W'(SETUP_CYC);
            next_st = BPF_SETUP;
         end
         BPF_SETUP: if (cnt <= CNT_W'(1)) begin
            next_st = BPF_STROBE;
            // page hit uses the shorter access time; sync adds 2 cycles
            next_cnt = wr ? CNT_W'(WP_CYC) :
                       pageHit ? CNT_W'(PACC_CYC + 2) : CNT_W'(ACC_CYC + 2);
            next_wen = ~wr;
            next_oen = wr;
         end else next_cnt = cnt - CNT_W'(1);
         BPF_STROBE: if (cnt <= CNT_W'(1)) begin
            if (!wr) next_rdata = syncB;
            next_wen = 1'b1;
            next_oen = 1'b1;
            next_cnt = CNT_W'(WPH_CYC);
            next_st = BPF_HOLD;
         end else next_cnt = cnt - CNT_W'(1);
         BPF_HOLD: if (cnt <= CNT_W'(1)) begin
            next_ce = 1'b1;
            next_oe = 1'b0;
            next_done = 1'b1;
            next_st = BPF_IDLE;
         end else next_cnt = cnt - CNT_W'(1);
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         st <= BPF_IDLE;
         cnt <= '0;
         wr <= 1'b0;
         rdata <= '0;
         pinAddr <= '0;
         pinDataOut <= '0;
         done <= 1'b0;
         pinDataOe <= 1'b0;
         chipEnN <= 1'b1;
         outEnN <= 1'b1;
         writeEnN <= 1'b1;
         syncA <= '0;
         syncB <= '0;
      end else begin
         st <= next_st;
         cnt <= next_cnt;
         wr <= next_wr;
         rdata <= next_rdata;
         pinAddr <= next_addr;
         pinDataOut <= next_dOut;
         done <= next_done;
         pinDataOe <= next_oe;
         chipEnN <= next_ce;
         outEnN <= next_oen;
         writeEnN <= next_wen;
         syncA <= pinDataIn;
         syncB <= syncA;
      end
   end
   assign busy = (st != BPF_IDLE);

   a_strobe_excl: assert property (@(posedge clk) disable iff (!rstn)
      !(!outEnN && !writeEnN)) else $error("read and write strobes both active"); // see R06
   a_drive_write: assert property (@(posedge clk) disable iff (!rstn)
      !writeEnN |-> pinDataOe && !chipEnN) else $error("write strobe without data drive"); // see R19
   a_cycle_done: assert property (@(posedge clk) disable iff (!rstn)
      $fell(writeEnN) |-> ##[1:20] done) else $error("write cycle did not finish"); // see R06
endmodule
`default_nettype wire

// ==== logic/bpf_host_ctrl.sv ====
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// R01: Array has four banks; program or erase in one, read another.
// R02: At most one embedded operation plus one read of another bank.
// R03: Outer banks hold eight 4 Kw sectors then 32 Kw; inner uniform.
// R04: Small boot sectors exist at both top and bottom.
// R05: Reads go in 8-word pages; hits inside a page are faster.
// R06: Commands are plain bus writes feeding the device state machine.
// R07: Device latches address and data on each command write.
// R08: Fast-program mode needs two writes per word instead of four.
// R09: Host polls data-complement bit and toggle bit for completion.
// R10: After finishing, device returns to array read mode.
// R11: Sector erase leaves other sectors untouched; clears whole sector.
// R12: Device blocks writes during supply transitions.
// R13: Device rejects program and erase on protected sectors.
// R14: Erase suspend allows reads and programs outside erased sector; the model ignores program writes while suspended.
// R15: One-time region reads in erase suspend need entry and exit.
// R16: Program suspend allows reads outside the target sector.
// R17: Protection and query areas in program suspend need entry and exit.
// R18: Device sleeps on stable address; host can select standby.
// R19: Data moves as 16-bit words on sixteen two-way pins.
// R20: Device ships fully erased.
// R21: Erased words read all ones; programming only clears bits.
module bpf_host_ctrl
   import bpf_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              rstn,
   input  wire logic              reqValid,
   input  wire logic [2:0]        reqOp,
   input  wire logic [ADDR_W-1:0] reqAddr,
   input  wire logic [DATA_W-1:0] reqData,
   input  wire logic              fastProgEn,
   input  wire logic              standbyReq,
   input  wire logic [DATA_W-1:0] word_data_pins_in,
   output logic                   reqReady,
   output logic                   rspValid,
   output logic [DATA_W-1:0]      rspData,
   output logic                   rspFail,
   output logic                   opBusy,
   output logic [ADDR_W-1:0]      addrPins,
   output logic [DATA_W-1:0]      word_data_pins_out,
   output logic                   word_data_pins_oe,
   output logic                   chipEnN,
   output logic                   outEnN,
   output logic                   writeEnN
);
   typedef enum logic [2:0] {
      BPF_READY, BPF_WSEQ, BPF_RD, BPF_POLL1, BPF_POLL2, BPF_RESP
   } bpf_st_t;

   bpf_st_t           st, next_st;
   bpf_op_t           op, next_op;
   logic [2:0]        step, next_step;
   logic [ADDR_W-1:0] addr, next_addr, pageTag, next_pageTag;
   logic [DATA_W-1:0] data, next_data, poll, next_poll, rdv, next_rdv;
   logic              pageOk, next_pageOk, fail, next_fail, next_rspValid, embBusy;
   logic              next_embBusy, cycStart, cycWr, cycBusy, cycDone, next_reqReady;
   logic [ADDR_W-1:0] cycAddr;
   logic [DATA_W-1:0] cycData, cycRdata;

   // length of the write sequence for an operation
   function automatic logic [2:0] seqLen(input bpf_op_t o);
      unique case (o)
         BPF_OP_PROG:  seqLen = 3'h4;
         BPF_OP_FPROG: seqLen = 3'h2;
         BPF_OP_ERASE: seqLen = 3'h6;
         default:      seqLen = 3'h1;
      endcase
   endfunction

   // address and data of write number s of the sequence
   function automatic logic [ADDR_W+DATA_W-1:0] seqWord(input bpf_op_t o, input logic [2:0] s,
         input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      logic [2:0] k;
      k = (o == BPF_OP_FPROG) ? s + 3'h2 : s;
      seqWord = {a, d};
      // only array words are ever read, so no special-region entry or exit follows a suspend
      if (o == BPF_OP_SUSPEND) seqWord = {a, CMD_SUSP}; // see R15 R17
      else if (o == BPF_OP_RESUME) seqWord = {a, CMD_RES};
      else if (o == BPF_OP_RESET) seqWord = {a, CMD_RESET};
      // the second unlock pair belongs to erase only; program ends on its data word
      else if (k == 3'h0 || (k == 3'h3 && o == BPF_OP_ERASE)) seqWord = {UNLOCK_A1, UNLOCK_D1};
      else if (k == 3'h1 || (k == 3'h4 && o == BPF_OP_ERASE)) seqWord = {UNLOCK_A2, UNLOCK_D2};
      else if (k == 3'h2)
         seqWord = (o == BPF_OP_FPROG) ? {a, CMD_PROG} :
                   {UNLOCK_A1, (o == BPF_OP_ERASE) ? CMD_ERASE : CMD_PROG};
      else if (o == BPF_OP_ERASE) seqWord = {a, CMD_SECT};
   endfunction

   logic [ADDR_W+DATA_W-1:0] sw;
   assign sw = seqWord(op, step, addr, data);
   assign cycAddr = (st == BPF_WSEQ) ? sw[ADDR_W+DATA_W-1:DATA_W] : addr;
   assign cycData = sw[DATA_W-1:0];

   always_comb begin
      next_st = st;
      next_op = op;
      next_step = step;
      next_addr = addr;
      next_data = data;
      next_poll = poll;
      next_rdv = rdv;
      next_fail = fail;
      next_pageOk = pageOk;
      next_pageTag = pageTag;
      next_embBusy = embBusy;
      next_rspValid = 1'b0;
      cycStart = 1'b0;
      cycWr = 1'b0;
      unique case (st)
         // one request at a time keeps at most one embedded operation live
         BPF_READY: if (reqValid && reqReady && !standbyReq) begin // see R02
            next_op = bpf_op_t'(reqOp);
            // fast program only while the device is in that mode
            if (bpf_op_t'(reqOp) == BPF_OP_PROG && fastProgEn) next_op = BPF_OP_FPROG; // see R08
            next_addr = reqAddr;
            next_data = reqData;
            next_step = '0;
            next_fail = 1'b0;
            next_st = (bpf_op_t'(reqOp) == BPF_OP_READ) ? BPF_RD : BPF_WSEQ;
         end
         BPF_WSEQ: begin
            cycWr = 1'b1;
            cycStart = !cycBusy && !cycDone;
            if (cycDone) begin
               next_pageOk = 1'b0;
               if (step == seqLen(op) - 3'h1) begin
                  if (op == BPF_OP_PROG || op == BPF_OP_FPROG || op == BPF_OP_ERASE) begin
                     next_embBusy = 1'b1;
                     next_st = BPF_POLL1; // see R09
                  end else begin
                     // each embedded operation is polled to its end before the answer,
                     // so a resume leaves nothing of ours running
                     next_embBusy = 1'b0;
                     next_st = BPF_RESP;
                  end
               end else next_step = step + 3'h1;
            end
         end
         BPF_RD: begin
            cycStart = !cycBusy && !cycDone;
            if (cycDone) begin
               next_rdv = cycRdata;
               next_pageOk = 1'b1;
               next_pageTag = addr; // see R05
               next_st = BPF_RESP;
            end
         end
         BPF_POLL1: begin
            cycStart = !cycBusy && !cycDone;
            if (cycDone) begin
               next_poll = cycRdata;
               next_st = BPF_POLL2;
            end
         end
         BPF_POLL2: begin
            cycStart = !cycBusy && !cycDone;
            if (cycDone) begin
               // toggle bit still flipping means the device is working
               if (cycRdata[TOGGLE_BIT] == poll[TOGGLE_BIT]) begin // see R09
                  next_embBusy = 1'b0;
                  // erase expects all ones, program the written bit 7
                  next_fail = (op == BPF_OP_ERASE) ? (cycRdata != ERASED_W) :
                              (cycRdata[POLL_BIT] != data[POLL_BIT]); // see R21
                  next_rdv = cycRdata;
                  next_st = BPF_RESP; // see R10
               end else begin
                  next_poll = cycRdata;
               end
            end
         end
         BPF_RESP: begin
            next_rspValid = 1'b1;
            next_st = BPF_READY;
         end
         default: next_st = BPF_READY;
      endcase
      next_reqReady = (next_st == BPF_READY) && !next_rspValid && !standbyReq;
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         st <= BPF_READY;
         op <= BPF_OP_READ;
         step <= '0;
         addr <= '0;
         data <= '0;
         poll <= '0;
         rdv <= '0;
         fail <= 1'b0;
         pageOk <= 1'b0;
         pageTag <= '0;
         embBusy <= 1'b0;
         rspValid <= 1'b0;
         reqReady <= 1'b0;
      end else begin
         st <= next_st;
         op <= next_op;
         step <= next_step;
         addr <= next_addr;
         data <= next_data;
         poll <= next_poll;
         rdv <= next_rdv;
         fail <= next_fail;
         pageOk <= next_pageOk;
         pageTag <= next_pageTag;
         embBusy <= next_embBusy;
         rspValid <= next_rspValid;
         reqReady <= next_reqReady;
      end
   end

   assign rspData = rdv;
   assign rspFail = fail;
   assign opBusy = embBusy;

   bpf_bus_cycle u_cyc (
      .clk        (clk),
      .rstn       (rstn),
      .start      (cycStart),
      .isWrite    (cycWr),
      .pageHit    (pageOk && pageTag[ADDR_W-1:PAGE_W] == addr[ADDR_W-1:PAGE_W]),
      .addr       (cycAddr),
      .wdata      (cycData),
      .pinDataIn  (word_data_pins_in),
      .busy       (cycBusy),
      .done       (cycDone),
      .rdata      (cycRdata),
      .pinAddr    (addrPins),
      .pinDataOut (word_data_pins_out),
      .pinDataOe  (word_data_pins_oe),
      .chipEnN    (chipEnN),
      .outEnN     (outEnN),
      .writeEnN   (writeEnN)
   );

   a_resp_pulse: assert property (@(posedge clk) disable iff (!rstn)
      rspValid |=> !rspValid) else $error("response held more than one cycle"); // see R10
   a_ready_idle: assert property (@(posedge clk) disable iff (!rstn)
      reqReady |-> chipEnN) else $error("ready while bus cycle running"); // see R06
   a_poll_after: assert property (@(posedge clk) disable iff (!rstn)
      (st == BPF_WSEQ && cycDone && step == seqLen(op) - 3'h1 &&
       (op == BPF_OP_PROG || op == BPF_OP_FPROG || op == BPF_OP_ERASE)) |=> opBusy)
      else $error("embedded operation not tracked"); // see R09
   a_fast_two: assert property (@(posedge clk) disable iff (!rstn)
      (st == BPF_WSEQ && op == BPF_OP_FPROG) |-> step <= 3'h1)
      else $error("fast program used more than two writes"); // see R08
   a_std_four: assert property (@(posedge clk) disable iff (!rstn)
      (st == BPF_WSEQ && op == BPF_OP_PROG) |-> step <= 3'h3)
      else $error("program used more than four writes"); // see R06
   a_no_standby: assert property (@(posedge clk) disable iff (!rstn)
      (standbyReq && st == BPF_READY) |=> st == BPF_READY)
      else $error("request taken during standby"); // see R18
   a_oe_release: assert property (@(posedge clk) disable iff (!rstn)
      (st == BPF_POLL1 || st == BPF_RD) && !outEnN |-> !word_data_pins_oe)
      else $error("host drives data during read"); // see R19
endmodule
`default_nettype wire

// ==== logic/bpf_pkg.sv ====
package bpf_pkg;
   localparam int ADDR_W = 23;
   localparam int DATA_W = 16;
   localparam int CLK_NS = 8;
   // bus timing in ns, rounded up to whole cycles (least times)
   localparam int T_ACC_NS   = 70;
   localparam int T_PACC_NS  = 30;
   localparam int T_WP_NS    = 40;
   localparam int T_WPH_NS   = 30;
   localparam int T_SETUP_NS = 10;
   localparam int ACC_CYC   = (T_ACC_NS + CLK_NS - 1) / CLK_NS;
   localparam int PACC_CYC  = (T_PACC_NS + CLK_NS - 1) / CLK_NS;
   localparam int WP_CYC    = (T_WP_NS + CLK_NS - 1) / CLK_NS;
   localparam int WPH_CYC   = (T_WPH_NS + CLK_NS - 1) / CLK_NS;
   localparam int SETUP_CYC = (T_SETUP_NS + CLK_NS - 1) / CLK_NS;
   localparam int CNT_W = 5;
   localparam int PAGE_W = 3;
   localparam logic [ADDR_W-1:0] UNLOCK_A1 = 23'h000555;
   localparam logic [ADDR_W-1:0] UNLOCK_A2 = 23'h0002AA;
   localparam logic [DATA_W-1:0] UNLOCK_D1 = 16'h00AA;
   localparam logic [DATA_W-1:0] UNLOCK_D2 = 16'h0055;
   localparam logic [DATA_W-1:0] CMD_PROG  = 16'h00A0;
   localparam logic [DATA_W-1:0] CMD_ERASE = 16'h0080;
   localparam logic [DATA_W-1:0] CMD_SECT  = 16'h0030;
   localparam logic [DATA_W-1:0] CMD_SUSP  = 16'h00B0;
   localparam logic [DATA_W-1:0] CMD_RES   = 16'h0030;
   localparam logic [DATA_W-1:0] CMD_RESET = 16'h00F0;
   localparam logic [DATA_W-1:0] ERASED_W  = 16'hFFFF;
   localparam int POLL_BIT   = 7;
   localparam int TOGGLE_BIT = 6;
   typedef enum logic [2:0] {
      BPF_OP_READ, BPF_OP_PROG, BPF_OP_FPROG, BPF_OP_ERASE,
      BPF_OP_SUSPEND, BPF_OP_RESUME, BPF_OP_RESET
   } bpf_op_t;
endpackage

// ==== test/bpf_flash_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module bpf_flash_model
   import bpf_pkg::*;
#(
   parameter int          BUSY_CYC  = 200,
   parameter logic [11:0] PROT_SECT = 12'h0C0
)(
   input  wire logic              clk,
   input  wire logic [ADDR_W-1:0] addrPins,
   input  wire logic [DATA_W-1:0] hostData,
   input  wire logic              hostOe,
   input  wire logic              chipEnN,
   input  wire logic              outEnN,
   input  wire logic              writeEnN,
   output logic [DATA_W-1:0]      pinLevel
);
   logic [DATA_W-1:0] mem [int];
   logic [DATA_W-1:0] rd;
   logic [DATA_W-1:0] lastLvl;
   logic [DATA_W-1:0] pData;
   logic [ADDR_W-1:0] pAddr;
   logic              pErase;
   logic              susp;
   logic              tog;
   logic              supplyLow;
   int                busyCnt;
   int                seqSt;
   int                nWrites;
   initial begin
      busyCnt = 0;
      seqSt = 0;
      nWrites = 0;
      susp = 1'b0;
      tog = 1'b0;
      supplyLow = 1'b0;
      lastLvl = 16'h0000;
   end
   // outer banks open and close with eight 4 Kw sectors
   function automatic logic [11:0] sect(input logic [ADDR_W-1:0] a);
      if ((a[22:21] == 2'h0 && a[20:15] == 6'h00) || (a[22:21] == 2'h3 && a[20:15] == 6'h3F))
         return {1'b1, a[22:12]};
      return {4'h0, a[22:15]};
   endfunction
   // a busy bank shows status, or only its busy sector while suspended; the others read array
   function automatic logic [DATA_W-1:0] rdFn(input logic [ADDR_W-1:0] a);
      if (busyCnt > 0 && a[22:21] == pAddr[22:21] && !(susp && sect(a) != sect(pAddr)))
         return {8'h00, pErase ? 1'b0 : ~pData[7], tog, 6'h00};
      // absent words read erased
      return mem.exists(int'(a)) ? mem[int'(a)] : ERASED_W;
   endfunction
   // command writes feed the sequencer with address and data
   // a low supply blocks every write
   always @(posedge writeEnN) if (!chipEnN && !supplyLow) begin
      nWrites++;
      if (hostData == CMD_RESET) begin
         seqSt = 0;
      end else if (busyCnt > 0) begin
         if (hostData == CMD_SUSP) susp = 1'b1;
         else if (hostData == CMD_RES) susp = 1'b0;
      end else begin
         case (seqSt)
            // a bare program code opens the two-write program
            0: seqSt = (hostData == UNLOCK_D1 && addrPins == UNLOCK_A1) ? 1 :
                       (hostData == CMD_PROG) ? 3 : 0;
            1: seqSt = (hostData == UNLOCK_D2 && addrPins == UNLOCK_A2) ? 2 : 0;
            2: seqSt = (hostData == CMD_PROG) ? 3 : (hostData == CMD_ERASE) ? 4 : 0;
            4: seqSt = (hostData == UNLOCK_D1) ? 5 : 0;
            5: seqSt = (hostData == UNLOCK_D2) ? 6 : 0;
            default: begin
               // protected sectors ignore the operation
               if ((seqSt == 3 || hostData == CMD_SECT) && sect(addrPins) != PROT_SECT) begin
                  pAddr = addrPins;
                  pData = hostData;
                  pErase = (seqSt == 6);
                  busyCnt = BUSY_CYC;
               end
               seqSt = 0;
            end
         endcase
      end
   end
   // back to array read once done
   always @(posedge clk) if (busyCnt > 0 && !susp) begin
      busyCnt--;
      // program only clears bits
      if (busyCnt == 0 && !pErase) mem[int'(pAddr)] = rdFn(pAddr) & pData;
      // erase clears one whole sector
      if (busyCnt == 0 && pErase) foreach (mem[k]) if (sect(ADDR_W'(k)) == sect(pAddr))
         mem[k] = ERASED_W;
   end
   always @(negedge outEnN) if (!chipEnN) tog = ~tog;
   always @(addrPins or chipEnN or outEnN or tog or busyCnt or susp) rd = rdFn(addrPins);
   // undriven pins flip every cycle so a stale capture shows
   assign pinLevel = hostOe ? hostData : (!chipEnN && !outEnN) ? rd : ~lastLvl;
   always @(posedge clk) lastLvl <= pinLevel;
endmodule
`default_nettype wire

// ==== test/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import bpf_pkg::*;
;
   localparam int BUSY = 200;
   logic              clk = 1'b0;
   logic              rstn = 1'b0;
   logic              reqValid = 1'b0;
   logic [2:0]        reqOp = 3'h0;
   logic [ADDR_W-1:0] reqAddr = 23'h000000;
   logic [DATA_W-1:0] reqData = 16'h0000;
   logic              fastProgEn = 1'b0;
   logic              standbyReq = 1'b0;
   logic [DATA_W-1:0] pinsIn, pinsOut, rspData, got;
   logic [ADDR_W-1:0] addrPins;
   logic              reqReady, rspValid, rspFail, opBusy, pinsOe;
   logic              chipEnN, outEnN, writeEnN, gotFail, sawBusy;
   int                nFail = 0;
   int                checksDone = 0;
   int                cyc;
   always #(CLK_NS / 2) clk = ~clk;
   bpf_host_ctrl u_dut (.clk(clk), .rstn(rstn), .reqValid(reqValid), .reqOp(reqOp),
      .reqAddr(reqAddr), .reqData(reqData), .fastProgEn(fastProgEn),
      .standbyReq(standbyReq), .word_data_pins_in(pinsIn), .reqReady(reqReady),
      .rspValid(rspValid), .rspData(rspData), .rspFail(rspFail), .opBusy(opBusy),
      .addrPins(addrPins), .word_data_pins_out(pinsOut), .word_data_pins_oe(pinsOe),
      .chipEnN(chipEnN), .outEnN(outEnN), .writeEnN(writeEnN));
   bpf_flash_model #(.BUSY_CYC(BUSY)) u_mem (.clk(clk), .addrPins(addrPins),
      .hostData(pinsOut), .hostOe(pinsOe), .chipEnN(chipEnN), .outEnN(outEnN),
      .writeEnN(writeEnN), .pinLevel(pinsIn));
   task automatic testDone();
      $display("checks %0d mismatches %0d", checksDone, nFail);
      if (nFail == 0 && checksDone > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic chk16(input logic [DATA_W-1:0] g, input logic [DATA_W-1:0] e, input string m);
      checksDone++;
      if (g !== e) begin
         nFail++;
         $display("ERROR %0t: %s got %h expected %h", $time, m, g, e);
      end
   endtask
   task automatic chk1(input logic g, input logic e, input string m);
      chk16({15'h0000, g}, {15'h0000, e}, m);
   endtask
   task automatic bound(input int k);
      if (k > 5000) begin
         nFail++;
         $display("ERROR %0t: wait bound used up", $time);
         testDone();
      end
   endtask
   // called at a falling edge; returns at the falling edge that sees rspValid
   task automatic req(input logic [2:0] op, input logic [ADDR_W-1:0] a,
                      input logic [DATA_W-1:0] d);
      int k;
      for (k = 0; reqReady !== 1'b1; k++) begin
         bound(k);
         @(negedge clk);
      end
      reqOp = op;
      reqAddr = a;
      reqData = d;
      reqValid = 1'b1;
      @(negedge clk);
      reqValid = 1'b0;
      sawBusy = 1'b0;
      for (cyc = 1; rspValid !== 1'b1; cyc++) begin
         bound(cyc);
         sawBusy = sawBusy | opBusy;
         @(negedge clk);
      end
      got = rspData;
      gotFail = rspFail;
   endtask
   task automatic tErased();
      req(3'h0, 23'h000100, 16'h0000);
      chk16(got, ERASED_W, "fresh word");
      $display("test erased done");
   endtask
   task automatic tProgram();
      int n0;
      n0 = u_mem.nWrites;
      req(3'h1, 23'h000123, 16'h5A3C);
      chk1(gotFail, 1'b0, "program status");
      chk1(cyc > BUSY, 1'b1, "waited for completion");
      chk1(sawBusy, 1'b1, "busy while embedded");
      chk1(opBusy, 1'b0, "idle after program");
      chk16(16'(u_mem.nWrites - n0), 16'h0004, "normal write count");
      req(3'h0, 23'h000123, 16'h0000);
      chk16(got, 16'h5A3C, "program readback");
      req(3'h1, 23'h000123, 16'hF0F0);
      chk1(gotFail, 1'b1, "ones cannot return");
      req(3'h0, 23'h000123, 16'h0000);
      chk16(got, 16'h5030, "bits only cleared");
      $display("test program done");
   endtask
   task automatic tFast();
      int n0;
      n0 = u_mem.nWrites;
      fastProgEn = 1'b1;
      req(3'h1, 23'h000200, 16'h1234);
      fastProgEn = 1'b0;
      chk16(16'(u_mem.nWrites - n0), 16'h0002, "fast write count");
      $display("test fast done");
   endtask
   task automatic tPage();
      int miss;
      req(3'h0, 23'h000200, 16'h0000);
      miss = cyc;
      chk16(got, 16'h1234, "page first word");
      req(3'h0, 23'h000203, 16'h0000);
      chk16(got, ERASED_W, "page other word");
      chk1(cyc < miss, 1'b1, "page hit faster");
      $display("test page done");
   endtask
   task automatic tErase();
      logic [ADDR_W-1:0] pa [6] = '{23'h001010, 23'h002010, 23'h008010,
                                    23'h010010, 23'h7FF010, 23'h7FE010};
      for (int i = 0; i < 6; i++) req(3'h1, pa[i], 16'(pa[i]));
      for (int i = 0; i < 6; i += 2) begin
         req(3'h3, pa[i], 16'h0000);
         chk1(gotFail, 1'b0, "erase status");
      end
      for (int i = 0; i < 6; i++) begin
         req(3'h0, pa[i], 16'h0000);
         chk16(got, (i % 2) ? 16'(pa[i]) : ERASED_W, "sector erase");
      end
      $display("test erase done");
   endtask
   task automatic tProtect();
      req(3'h1, 23'h600000, 16'h0000);
      chk1(gotFail, 1'b1, "protected program");
      req(3'h0, 23'h600000, 16'h0000);
      chk16(got, ERASED_W, "protected unchanged");
      u_mem.supplyLow = 1'b1;
      req(3'h1, 23'h000300, 16'h0000);
      u_mem.supplyLow = 1'b0;
      chk1(gotFail, 1'b1, "write inhibited");
      req(3'h0, 23'h000300, 16'h0000);
      chk16(got, ERASED_W, "inhibited unchanged");
      $display("test protect done");
   endtask
   task automatic tStandby();
      standbyReq = 1'b1;
      repeat (10) begin
         @(negedge clk);
         chk1(reqReady, 1'b0, "standby refuses");
         chk1(chipEnN, 1'b1, "standby chip idle");
      end
      standbyReq = 1'b0;
      $display("test standby done");
   endtask
   task automatic tCmds();
      for (int op = 4; op < 7; op++) req(3'(op), UNLOCK_A1, 16'h0000);
      req(3'h0, 23'h000123, 16'h0000);
      chk16(got, 16'h5030, "read after commands");
      chk1(opBusy, 1'b0, "idle after resume");
      $display("test commands done");
   endtask
   initial begin
      repeat (20) @(negedge clk);
      rstn = 1'b1;
      tErased();
      tProgram();
      tFast();
      tPage();
      tErase();
      tProtect();
      tStandby();
      tCmds();
      testDone();
   end
endmodule
`default_nettype wire
